// ### tb.sv
// Register level recovery tests for the timer outputs
`timescale 1ns/1ns
`default_nettype none
module tb;
	import timer_output_pkg::*;
	logic        clk_i, rst_i, we_i, cyc_i, stb_i, phase_a_i, phase_b_i, ack_o;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic [9:0]  pin_o, pin_oe_o, line;
	int          fails, samples_checked;
	timer_output_top dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
		.dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.phase_a_i(phase_a_i), .phase_b_i(phase_b_i), .dat_o(dat_o),
		.ack_o(ack_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
	timer_load_model u_load (.pin_i(pin_o), .oe_i(pin_oe_o), .port_i(10'h3ff),
		.line_o(line));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) phase_a_i <= rst_i ? 1'b0 : ~phase_a_i;
	// ********************
	// Bus tasks
	// ********************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task wb(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
		// No own limit: the watchdog ends a hung wait
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(a, d, 1'b1);
		repeat (4) @(posedge clk_i);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		tally_and_finish;
	end
	// ********************
	// Recovery sequence
	// ********************
	initial begin
		logic [15:0] cnt;
		{cyc_i, stb_i, we_i, phase_b_i} = 4'h0;
		{adr_i, dat_i, sel_i} = '0;
		rst_i = 1'b1;
		fails = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(pin_o, 0);
		chk(pin_oe_o, 0);
		wr(ADR_CTRL0, 32'h60);
		wb(ADR_STAT0, 0, 1'b0);
		chk(q[16], 1);
		wr(ADR_CMP0, 32'hffff0008);
		wr(ADR_PINFN, 32'h1);
		chk(line[0], 1);
		chk(pin_oe_o[0], 1);
		wr(ADR_START, 32'h1);
		repeat (20) @(posedge clk_i);
		chk(line[0], 0);
		wr(ADR_PINFN, 32'h0);
		chk(line[0], 1);
		wr(ADR_START, 32'h0);
		wb(ADR_STAT0, 0, 1'b0);
		cnt = q[15:0];
		chk(cnt > 16'h0008, 1);
		repeat (10) @(posedge clk_i);
		wb(ADR_STAT0, 0, 1'b0);
		chk(q[16:0], {1'b0, cnt});
		wr(ADR_CTRL0, 32'h1);
		wr(ADR_CTRL0, 32'h661);
		wb(ADR_STAT0, 0, 1'b0);
		chk(q[17:16], 2'b01);
		wr(ADR_CTRL0, 32'h2);
		wr(ADR_CTRL0, 32'h642);
		wb(ADR_STAT0, 0, 1'b0);
		chk(q[17:16], 2'b11);
		// Same-mode restart: no mode step, straight to pin init
		wr(ADR_PINFN, 32'h1);
		wr(ADR_START, 32'h1);
		repeat (20) @(posedge clk_i);
		wr(ADR_PINFN, 32'h0);
		wr(ADR_START, 32'h0);
		wr(ADR_CTRL0, 32'h442);
		wb(ADR_STAT0, 0, 1'b0);
		chk(q[17:16], 2'b01);
		// Each channel is tried with both restricted modes
		for (int c = 0; c < 5; c++) begin
			wr(ADR_CTRL0 + CH_STRIDE * 8'(c), 32'h0);
			wr(ADR_CTRL0 + CH_STRIDE * 8'(c), 32'h2);
			wb(ADR_CTRL0 + CH_STRIDE * 8'(c), 0, 1'b0);
			chk(q[2:0], c < 3 ? 3'h2 : 3'h0);
			wr(ADR_CTRL0 + CH_STRIDE * 8'(c), 32'h3);
			wb(ADR_CTRL0 + CH_STRIDE * 8'(c), 0, 1'b0);
			chk(q[2:0], (c == 1 || c == 2) ? 3'h3 : (c < 3 ? 3'h2 : 3'h0));
		end
		// Phase counting on ch1: B low, so A rises count up
		wr(ADR_START, 32'h2);
		wr(ADR_START, 32'h0);
		wb(8'h44, 0, 1'b0);
		chk(q[15:0] > 16'h0000 && q[15:0] < 16'h0100, 1);
		wr(8'h30, 32'h60);
		wb(8'h50, 0, 1'b0);
		chk(q[16], 0);
		wr(ADR_OMEN, 32'h4);
		wr(8'h30, 32'h60);
		wb(8'h50, 0, 1'b0);
		chk(q[16], 1);
		wr(ADR_PINFN, 32'h100);
		chk(line[8], 1);
		chk(pin_oe_o[8], 1);
		wr(ADR_OMEN, 32'h0);
		chk(pin_oe_o[8], 0);
		// Ch3 into complementary, then reset-synchronous mode
		wr(ADR_OMEN, 32'h3);
		wr(8'h28, 32'h660);
		wb(8'h4c, 0, 1'b0);
		chk(q[17:16], 2'b11);
		wr(8'h28, 32'h0);
		wr(ADR_OMEN, 32'h0);
		wr(ADR_OLC, 32'h1);
		wr(8'h28, 32'h4);
		wb(8'h4c, 0, 1'b0);
		chk(q[17:16], 2'b01);
		wr(ADR_OMEN, 32'h3);
		wr(ADR_PINFN, 32'hc0);
		chk(pin_oe_o[7:6], 2'b11);
		chk(pin_o[7:6], 2'b01);
		wr(ADR_START, 32'h8);
		wr(ADR_PINFN, 32'h0);
		chk(line[7:6], 2'b11);
		wr(ADR_START, 32'h0);
		wr(8'h28, 32'h0);
		wb(8'h4c, 0, 1'b0);
		chk(q[17:16], 2'b00);
		wr(ADR_OMEN, 32'h0);
		wr(ADR_OLC, 32'h1);
		wr(8'h28, 32'h5);
		wb(8'h4c, 0, 1'b0);
		chk(q[17:16], 2'b01);
		wr(ADR_OMEN, 32'h3);
		wr(8'h28, 32'h0);
		wb(8'h4c, 0, 1'b0);
		chk(q[17:16], 2'b10);
		wb(8'hfc, 0, 1'b0);
		chk(q, 0);
		tally_and_finish;
	end
endmodule
`default_nettype wire

// ### timer_load_model.sv
// Loads on the compare pins, with the port taking over cut pins
`timescale 1ns/1ns
`default_nettype none
module timer_load_model #(
	parameter int N = 10
) (
	input  wire logic [N-1:0] pin_i,
	input  wire logic [N-1:0] oe_i,
	input  wire logic [N-1:0] port_i,
	output logic      [N-1:0] line_o
);
	// Port holds the inactive level while the timer is cut off
	assign line_o = (pin_i & oe_i) | (port_i & ~oe_i);
endmodule
`default_nettype wire

// ### timer_output_chk.sv
// Concurrent checks on the timer output ports
`timescale 1ns/1ns
`default_nettype none
module timer_output_chk
	import timer_output_pkg::*;
#(
	parameter int CH = NUM_CH
) (
	input wire logic            clk_i,
	input wire logic            rst_i,
	input wire logic [7:0]      adr_i,
	input wire logic [31:0]     dat_i,
	input wire logic [3:0]      sel_i,
	input wire logic            we_i,
	input wire logic            cyc_i,
	input wire logic            stb_i,
	input wire logic [31:0]     dat_o,
	input wire logic            ack_o,
	input wire logic [2*CH-1:0] pin_o,
	input wire logic [2*CH-1:0] pin_oe_o
);
	// ********************
	// Write tracking
	// ********************
	logic       take, wr;
	logic [2:0] since_ff, nxt_since;
	logic [4:0] run_ff, nxt_run;
	logic [3:0] omen_ff, nxt_omen;
	logic [5:0] pf_ff, nxt_pf;
	assign take = cyc_i & stb_i & ~ack_o;
	assign wr = take & we_i & (sel_i == 4'hf);
	always_comb begin
		nxt_since = (since_ff == 3'h7) ? since_ff : since_ff + 3'h1;
		nxt_run = run_ff;
		nxt_omen = omen_ff;
		nxt_pf = pf_ff;
		if (wr) begin
			nxt_since = 3'h0;
			if (adr_i == ADR_START) nxt_run = dat_i[4:0];
			if (adr_i == ADR_OMEN) nxt_omen = dat_i[3:0];
			if (adr_i == ADR_PINFN) nxt_pf = dat_i[5:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			since_ff <= 3'h7;
			run_ff <= 5'h00;
			omen_ff <= 4'h0;
			pf_ff <= 6'h00;
		end else begin
			since_ff <= nxt_since;
			run_ff <= nxt_run;
			omen_ff <= nxt_omen;
			pf_ff <= nxt_pf;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_req_ack; take |=> ack_o; endproperty
	a_req_ack: assert property (p_req_ack) else $error("no ack");
	property p_dat_zero; !ack_o |-> dat_o == 32'h0; endproperty
	a_dat_zero: assert property (p_dat_zero) else $error("stray data");
	property p_rst; disable iff (1'b0) rst_i |=> pin_o == '0 && pin_oe_o == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("pins after reset");
	property p_oe_cause; $changed(pin_oe_o) |-> since_ff < 3'h5; endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("oe moved");
	// Idle timer may only move pins shortly after software wrote
	property p_hold; $changed(pin_o) && run_ff == 5'h0 && $past(run_ff) == 5'h0
		|-> since_ff < 3'h5; endproperty
	a_hold: assert property (p_hold) else $error("stopped pin moved");
	property p_pf; wr && adr_i == ADR_PINFN |-> ##[1:4] pin_oe_o[5:0] == pf_ff;
	endproperty
	a_pf: assert property (p_pf) else $error("oe not routed");
	property p_omen; (pin_oe_o[9:6] & ~(omen_ff | $past(omen_ff) |
		$past(omen_ff, 2) | $past(omen_ff, 3))) == 4'h0; endproperty
	a_omen: assert property (p_omen) else $error("oe without enable");
endmodule
bind timer_output_top timer_output_chk #(.CH(CH)) u_chk (.clk_i(clk_i),
	.rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
	.pin_o(pin_o), .pin_oe_o(pin_oe_o));
`default_nettype wire

// ### timer_output_pkg.sv
// Shared constants and the per-channel compare output engine
`timescale 1ns/1ns
`default_nettype none
package timer_output_pkg;
	typedef enum logic [2:0] {
		mode_normal,
		mode_pwm1,
		mode_pwm2,
		mode_phase,
		mode_complementary_pwm,
		mode_reset_synchronous_pwm
	} mode_t;
	localparam int NUM_CH    = 5;
	localparam int CNT_W     = 16;
	localparam int IO_W      = 3;
	// Pin I/O control field: enable, initial level, match level
	localparam int IO_EN     = 2;
	localparam int IO_INIT   = 1;
	localparam int IO_MATCH  = 0;
	// Output level control fields
	localparam int OLC_LEVEL = 0;
	localparam int OLC_CYCLE = 1;
	// Byte offsets
	localparam logic [7:0] ADR_START  = 8'h00;
	localparam logic [7:0] ADR_OMEN   = 8'h04;
	localparam logic [7:0] ADR_OLC    = 8'h08;
	localparam logic [7:0] ADR_PINFN  = 8'h0c;
	localparam logic [7:0] ADR_CTRL0  = 8'h10;
	localparam logic [7:0] ADR_CMP0   = 8'h14;
	localparam logic [7:0] ADR_STAT0  = 8'h40;
	localparam logic [7:0] CH_STRIDE  = 8'h08;
	localparam logic [7:0] ST_STRIDE  = 8'h04;
	// Control and status register field positions
	localparam int CTRL_MODE  = 0;
	localparam int CTRL_IOA   = 4;
	localparam int CTRL_IOB   = 8;
	localparam int STAT_OUTA  = 16;
	localparam int STAT_OUTB  = 17;
	// Reset values; first channel behind master enable
	localparam logic [4:0]  START_RST = 5'h00;
	localparam logic [3:0]  OMEN_RST  = 4'h0;
	localparam logic [1:0]  OLC_RST   = 2'h0;
	localparam logic [9:0]  PINFN_RST = 10'h000;
	localparam logic [31:0] CTRL_RST  = 32'h00000000;
	localparam logic [31:0] CMP_RST   = 32'hffffffff;
	localparam int FIRST_OMEN_CH = 3;
endpackage

module timer_channel_out
	import timer_output_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          run_i,
	input  wire mode_t         mode_i,
	input  wire logic [IO_W-1:0] io_a_i,
	input  wire logic [IO_W-1:0] io_b_i,
	input  wire logic          io_wr_i,
	input  wire logic          init_ok_i,
	input  wire logic [W-1:0]  cmp_a_i,
	input  wire logic [W-1:0]  cmp_b_i,
	input  wire logic [1:0]    olc_i,
	input  wire logic          qa_rise_i,
	input  wire logic          qb_i,
	output logic [W-1:0]       cnt_o,
	output logic               out_a_o,
	output logic               out_b_o
);
	// Elaboration check: a one-bit counter cannot reach a compare
	if (W < 2) begin : g_w_chk
		$error("counter width too small");
	end
	logic [W-1:0] cnt_ff, nxt_cnt;
	logic         a_ff, nxt_a, b_ff, nxt_b;
	mode_t        last_ff, nxt_last;
	logic         ma, mb, lvl;

	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_a    = a_ff;
		nxt_b    = b_ff;
		nxt_last = mode_i;
		lvl      = olc_i[OLC_LEVEL];
		ma       = run_i && (cnt_ff == cmp_a_i);
		mb       = run_i && (cnt_ff == cmp_b_i);
		if (mode_i != last_ff) begin
			nxt_cnt = '0;
			if (mode_i == mode_complementary_pwm ||
			    mode_i == mode_reset_synchronous_pwm) begin
				nxt_a = lvl;
				nxt_b = ~lvl;
			end else if (last_ff == mode_complementary_pwm) begin
				nxt_a = 1'b0;
				nxt_b = 1'b0;
			end else if (last_ff == mode_reset_synchronous_pwm) begin
				nxt_a = 1'b0;
				nxt_b = 1'b1;
			end
		end else if (io_wr_i) begin
			if (init_ok_i && io_a_i[IO_EN] && mode_i != mode_pwm2) // R04
				nxt_a = io_a_i[IO_INIT]; // R02
			if (init_ok_i && io_b_i[IO_EN] && mode_i != mode_pwm1) // R03
				nxt_b = io_b_i[IO_INIT]; // R02
		end else if (run_i) begin
			case (mode_i)
				mode_phase: begin
					if (qa_rise_i)
						nxt_cnt = qb_i ? cnt_ff - 1'b1 : cnt_ff + 1'b1;
					if (ma && io_a_i[IO_EN]) nxt_a = io_a_i[IO_MATCH];
					if (mb && io_b_i[IO_EN]) nxt_b = io_b_i[IO_MATCH];
				end
				mode_pwm1: begin
					nxt_cnt = mb ? '0 : cnt_ff + 1'b1;
					// Both compares steer the A pin; B pin is left alone
					if (ma && io_a_i[IO_EN]) nxt_a = io_a_i[IO_MATCH];
					if (mb && io_b_i[IO_EN]) nxt_a = io_b_i[IO_MATCH];
				end
				mode_pwm2: begin
					// Compare A is the cycle register
					nxt_cnt = ma ? '0 : cnt_ff + 1'b1;
					if (ma && io_b_i[IO_EN]) nxt_b = io_b_i[IO_INIT];
					else if (mb && io_b_i[IO_EN]) nxt_b = io_b_i[IO_MATCH];
				end
				mode_complementary_pwm, mode_reset_synchronous_pwm: begin
					nxt_cnt = ma ? '0 : cnt_ff + 1'b1;
					if (ma) begin
						nxt_a = lvl;
						nxt_b = ~lvl;
					end else if (mb && olc_i[OLC_CYCLE]) begin
						nxt_a = ~lvl;
						nxt_b = lvl;
					end
				end
				default: begin
					nxt_cnt = cnt_ff + 1'b1;
					if (ma && io_a_i[IO_EN]) nxt_a = io_a_i[IO_MATCH]; // R02
					if (mb && io_b_i[IO_EN]) nxt_b = io_b_i[IO_MATCH]; // R02
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff  <= '0;
			a_ff    <= 1'b0; // R01
			b_ff    <= 1'b0; // R01
			last_ff <= mode_normal;
		end else begin
			cnt_ff  <= nxt_cnt;
			a_ff    <= nxt_a; // R17
			b_ff    <= nxt_b; // R17
			last_ff <= nxt_last;
		end
	end

	assign cnt_o   = cnt_ff;
	assign out_a_o = a_ff;
	assign out_b_o = b_ff;
endmodule
`default_nettype wire

// ### timer_output_top.sv
// Wishbone-controlled multi-channel timer compare outputs
`timescale 1ns/1ns
`default_nettype none
// Function
// [R01] After reset all compare outputs are low and no pin is driven.
// [R02] A pin I/O control write sets the initial level; a match sets match level.
// [R03] In PWM mode 1 a pin I/O control write leaves the B pin untouched.
// [R04] In PWM mode 2 the cycle register pin (A) is not initialised.
// [R05] PWM mode 2 is accepted only on channels 0 to 2.
// [R06] Phase counting mode is accepted only on channels 1 and 2.
// [R07] Software cuts pins to port output before stopping the counter.
// [R08] Software clears the start bit after cutover and before a mode change.
// [R09] Software sets the new mode first, then initialises pin levels.
// [R10] Restart in the same mode skips the mode step.
// [R11] Software restores pin function, then restarts counting.
// [R12] Complementary restart: normal mode, init, disable, outputs 3/4 off.
// [R13] Then level control, complementary mode, outputs 3/4 on, pins, start.
// [R14] Reset-synchronous restart follows the same order with its own mode.
// [R15] Channel 0-2 recoveries use the same order without master enable.
// [R16] Channels 3 and 4 need master enable before pin initialisation.
// [R17] A stopped counter holds each output until mode change or I/O write.
module timer_output_top
	import timer_output_pkg::*;
#(
	parameter int CH = NUM_CH
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        we_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        phase_a_i,
	input  wire logic        phase_b_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	output logic [2*CH-1:0]  pin_o,
	output logic [2*CH-1:0]  pin_oe_o
);
	if (CH != NUM_CH) begin : g_ch_chk
		$error("channel count fixed by register map");
	end

	// ***************************************************************
	// Register state
	// ***************************************************************
	logic [4:0]       start_ff, nxt_start;
	logic [3:0]       omen_ff, nxt_omen;
	logic [1:0]       olc_ff, nxt_olc;
	logic [9:0]       pinfn_ff, nxt_pinfn;
	logic [31:0]      ctrl_ff [CH], nxt_ctrl [CH];
	logic [31:0]      cmp_ff [CH], nxt_cmp [CH];
	logic [CH-1:0]    iowr_ff, nxt_iowr;
	logic             ack_ff, nxt_ack;
	logic [31:0]      rd_ff, nxt_rd;
	logic [2*CH-1:0]  pin_ff, nxt_pin, oe_ff, nxt_oe;
	logic [2:0]       qa_ff, qb_ff;
	logic [CNT_W-1:0] cnt_w [CH];
	logic [CH-1:0]    outa_w, outb_w;
	logic             req;
	logic [31:0]      mask;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	function automatic logic mode_ok(input int ch, input logic [2:0] m);
		mode_ok = 1'b1;
		if (m > 3'(mode_reset_synchronous_pwm))
			mode_ok = 1'b0;
		else if (m == 3'(mode_pwm2) && ch > 2) // R05
			mode_ok = 1'b0;
		else if (m == 3'(mode_phase) && (ch < 1 || ch > 2)) // R06
			mode_ok = 1'b0;
	endfunction

	function automatic logic omen_ch(input int ch, input logic [3:0] en,
		input logic b);
		if (ch < FIRST_OMEN_CH)
			omen_ch = 1'b1;
		else
			omen_ch = en[2*(ch-FIRST_OMEN_CH) + int'(b)];
	endfunction

	assign req = cyc_i && stb_i && !ack_ff;
	assign mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
		{8{sel_i[0]}}};

	// ***************************************************************
	// Bus slave: one wait state, unmapped reads zero
	// ***************************************************************
	always_comb begin
		nxt_start = start_ff;
		nxt_omen  = omen_ff;
		nxt_olc   = olc_ff;
		nxt_pinfn = pinfn_ff;
		nxt_ctrl  = ctrl_ff;
		nxt_cmp   = cmp_ff;
		nxt_iowr  = '0;
		nxt_ack   = req;
		nxt_rd    = '0;
		if (req && we_i) begin
			if (adr_i == ADR_START) begin
				nxt_start = 5'(merge(32'(start_ff), dat_i, mask));
			end else if (adr_i == ADR_OMEN) begin
				nxt_omen = 4'(merge(32'(omen_ff), dat_i, mask));
			end else if (adr_i == ADR_OLC) begin
				nxt_olc = 2'(merge(32'(olc_ff), dat_i, mask));
			end else if (adr_i == ADR_PINFN) begin
				nxt_pinfn = 10'(merge(32'(pinfn_ff), dat_i, mask));
			end else begin
				for (int c = 0; c < CH; c++) begin
					if (adr_i == ADR_CTRL0 + 8'(c) * CH_STRIDE) begin
						nxt_ctrl[c] = merge(ctrl_ff[c], dat_i, mask);
						if (!mode_ok(c, nxt_ctrl[c][CTRL_MODE +: 3]))
							nxt_ctrl[c][CTRL_MODE +: 3] =
								ctrl_ff[c][CTRL_MODE +: 3];
						nxt_iowr[c] = sel_i[0] || sel_i[1];
					end else if (adr_i == ADR_CMP0 + 8'(c) * CH_STRIDE) begin
						nxt_cmp[c] = merge(cmp_ff[c], dat_i, mask);
					end
				end
			end
		end else if (req) begin
			if (adr_i == ADR_START) begin
				nxt_rd = 32'(start_ff);
			end else if (adr_i == ADR_OMEN) begin
				nxt_rd = 32'(omen_ff);
			end else if (adr_i == ADR_OLC) begin
				nxt_rd = 32'(olc_ff);
			end else if (adr_i == ADR_PINFN) begin
				nxt_rd = 32'(pinfn_ff);
			end else begin
				for (int c = 0; c < CH; c++) begin
					if (adr_i == ADR_CTRL0 + 8'(c) * CH_STRIDE)
						nxt_rd = ctrl_ff[c] & 32'h00000777;
					else if (adr_i == ADR_CMP0 + 8'(c) * CH_STRIDE)
						nxt_rd = cmp_ff[c];
					else if (adr_i == ADR_STAT0 + 8'(c) * ST_STRIDE) begin
						nxt_rd = 32'(cnt_w[c]);
						nxt_rd[STAT_OUTA] = outa_w[c];
						nxt_rd[STAT_OUTB] = outb_w[c];
					end
				end
			end
		end
	end

	// ***************************************************************
	// Pin drive: timer level always on pin_o, driven only when pin function selects it
	// ***************************************************************
	always_comb begin
		for (int c = 0; c < CH; c++) begin
			nxt_pin[2*c]   = outa_w[c];
			nxt_pin[2*c+1] = outb_w[c];
			// Master enable gates channels 3 and 4 only
			nxt_oe[2*c]    = pinfn_ff[2*c] && omen_ch(c, omen_ff, 1'b0); // R01
			nxt_oe[2*c+1]  = pinfn_ff[2*c+1] && omen_ch(c, omen_ff, 1'b1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_ff <= START_RST;
			omen_ff  <= OMEN_RST;
			olc_ff   <= OLC_RST;
			pinfn_ff <= PINFN_RST; // R01
			for (int c = 0; c < CH; c++) begin
				ctrl_ff[c] <= CTRL_RST;
				cmp_ff[c]  <= CMP_RST;
			end
			iowr_ff  <= '0;
			ack_ff   <= 1'b0;
			rd_ff    <= '0;
			pin_ff   <= '0;
			oe_ff    <= '0;
			qa_ff    <= '0;
			qb_ff    <= '0;
		end else begin
			start_ff <= nxt_start;
			omen_ff  <= nxt_omen;
			olc_ff   <= nxt_olc;
			pinfn_ff <= nxt_pinfn;
			ctrl_ff  <= nxt_ctrl;
			cmp_ff   <= nxt_cmp;
			iowr_ff  <= nxt_iowr;
			ack_ff   <= nxt_ack;
			rd_ff    <= nxt_rd;
			pin_ff   <= nxt_pin;
			oe_ff    <= nxt_oe;
			// Two-stage synchronisers, third stage for edge detect
			qa_ff    <= {qa_ff[1:0], phase_a_i};
			qb_ff    <= {qb_ff[1:0], phase_b_i};
		end
	end

	// ***************************************************************
	// Channels
	// ***************************************************************
	for (genvar g = 0; g < CH; g++) begin : gen_ch
		mode_t mode_w;
		assign mode_w = mode_t'(ctrl_ff[g][CTRL_MODE +: 3]);
		timer_channel_out #(
			.W(CNT_W)
		) u_ch (
			.clk_i     (clk_i),
			.rst_i     (rst_i),
			.run_i     (start_ff[g]),
			.mode_i    (mode_w),
			.io_a_i    (ctrl_ff[g][CTRL_IOA +: IO_W]),
			.io_b_i    (ctrl_ff[g][CTRL_IOB +: IO_W]),
			.io_wr_i   (iowr_ff[g]),
			// Init of both pins ignored while a gated channel's A output enable is off
			.init_ok_i (omen_ch(g, omen_ff, 1'b0)), // R16
			.cmp_a_i   (cmp_ff[g][CNT_W-1:0]),
			.cmp_b_i   (cmp_ff[g][2*CNT_W-1:CNT_W]),
			.olc_i     (olc_ff),
			.qa_rise_i (qa_ff[1] && !qa_ff[2]),
			.qb_i      (qb_ff[1]),
			.cnt_o     (cnt_w[g]),
			.out_a_o   (outa_w[g]),
			.out_b_o   (outb_w[g])
		);
	end

	assign dat_o    = rd_ff;
	assign ack_o    = ack_ff;
	assign pin_o    = pin_ff;
	assign pin_oe_o = oe_ff;
endmodule
`default_nettype wire
